// ===== src/core_sleep_lockup_control.sv
// sleep, wake and lockup controller of the processor core with its register port
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps
module core_sleep_lockup_control
    import sleep_ctl_pkg::*;
#(
    parameter int RESTART_LEN = RESTART_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    // core instruction and exception side
    input wire logic i_wfi_op,
    input wire logic i_wfe_op,
    input wire logic i_handler_done,
    input wire logic i_exc_entry_ok,
    input wire logic i_irq_above_prio,
    input wire logic i_interrupt_mask_bit,
    input wire logic i_fault_mask_bit,
    input wire logic i_new_pending,
    input wire logic i_ext_event,
    input wire logic i_remote_sev,
    input wire logic i_debug_wake,
    input wire logic i_hard_fault,
    input wire logic i_in_nmi,
    input wire logic i_in_hard_fault,
    input wire logic i_nmi,
    input wire logic i_debug_halt,
    // clock gating and status
    output logic o_core_run,
    output logic o_cpu_clk_en,
    output logic o_sys_clk_en,
    output logic o_pll_en,
    output logic o_flash_en,
    output logic o_sleeping,
    output logic o_locked_up,
    output logic o_defer_handler,
    output logic o_irq
);
    // the restart counter is CNT_W bits wide, so longer restarts cannot be counted
    if (RESTART_LEN < 1 || RESTART_LEN > 255) begin : g_bad_restart_len
        $error("RESTART_LEN must lie in 1..255");
    end

    ctl_state_t state;
    ctl_state_t next_state;
    logic deep_mode;
    logic next_deep_mode;
    logic from_nmi;
    logic next_from_nmi;
    logic [CNT_W-1:0] restart_cnt;
    logic [CNT_W-1:0] next_restart_cnt;
    logic sleep_after_handler;
    logic deep_sleep_select;
    logic event_on_pending;
    logic next_sleep_after_handler;
    logic next_deep_sleep_select;
    logic next_event_on_pending;
    logic [NUM_EV-1:0] status;
    logic [NUM_EV-1:0] next_status;
    logic [NUM_EV-1:0] irq_mask;
    logic [NUM_EV-1:0] next_irq_mask;
    logic [NUM_EV-1:0] ev;
    logic [DATA_W-1:0] next_rdata;
    logic lock_entry;
    logic lock_release;
    logic event_now;
    logic latch_q;
    logic latch_set;
    logic latch_clear;
    logic sleep_entry;
    logic wake_pulse;

    wake_if w ();

    // event sources: external peripheral pulse, remote send, pending when enabled
    assign event_now = i_ext_event || i_remote_sev // R11
        || (event_on_pending && i_new_pending); // R10

    assign w.exc_entry_ok = i_exc_entry_ok;
    assign w.irq_above_prio = i_irq_above_prio;
    assign w.int_mask = i_interrupt_mask_bit;
    assign w.fault_mask = i_fault_mask_bit;
    assign w.event_now = event_now;
    assign w.latch_q = latch_q;
    assign w.debug_wake = i_debug_wake;

    wake_detect u_wake (
        .w(w)
    );

    // an event seen while asleep on wait-for-event is consumed by the wake itself
    assign latch_set = event_now && (state != ST_SLEEP_WFE); // R11
    assign latch_clear = ((state == ST_RUN) && i_wfe_op && latch_q) // R3
        || ((state == ST_SLEEP_WFE) && w.wake_wfe);

    event_latch u_latch (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_set(latch_set),
        .i_clear(latch_clear),
        .o_q(latch_q)
    );

    // a hard fault inside the nmi or hard fault handler has nowhere to escalate
    assign lock_entry = (state == ST_RUN) && i_hard_fault
        && (i_in_nmi || i_in_hard_fault); // R13
    // nmi cannot release a lockup that the nmi handler itself caused
    assign lock_release = i_debug_halt || (i_nmi && !from_nmi); // R14 R15

    // sleep state machine
    always_comb begin
        next_state = state;
        next_deep_mode = deep_mode;
        next_from_nmi = from_nmi;
        next_restart_cnt = restart_cnt;
        unique case (state)
            ST_RUN: begin
                if (lock_entry) begin
                    next_state = ST_LOCKUP; // R13
                    next_from_nmi = i_in_nmi; // R15
                end else if (i_wfi_op) begin
                    next_state = ST_SLEEP_WFI; // R1
                    next_deep_mode = deep_sleep_select; // R6
                end else if (i_wfe_op && !latch_q) begin
                    next_state = ST_SLEEP_WFE; // R2
                    next_deep_mode = deep_sleep_select; // R6
                end else if (i_wfe_op) begin
                    next_state = ST_RUN; // R3
                end else if (i_handler_done && sleep_after_handler) begin
                    next_state = ST_SLEEP_WFI; // R4
                    next_deep_mode = deep_sleep_select; // R6
                end
            end
            ST_SLEEP_WFI: begin
                if (w.wake_wfi) begin
                    next_state = deep_mode ? ST_RESTART : ST_RUN; // R7 R16
                    next_restart_cnt = '0;
                end
            end
            ST_SLEEP_WFE: begin
                if (w.wake_wfe) begin
                    next_state = deep_mode ? ST_RESTART : ST_RUN; // R9 R16
                    next_restart_cnt = '0;
                end
            end
            ST_RESTART: begin
                // core clock stays off until the pll and flash have settled
                if (restart_cnt == CNT_W'(RESTART_LEN - 1)) begin
                    next_state = ST_RUN; // R16
                    next_deep_mode = 1'b0;
                end else begin
                    next_restart_cnt = restart_cnt + CNT_W'(1);
                end
            end
            ST_LOCKUP: begin
                if (lock_release) begin
                    next_state = ST_RUN; // R14
                    next_from_nmi = 1'b0;
                end
            end
            default: begin
                next_state = ST_RUN;
                next_deep_mode = 1'b0;
                next_from_nmi = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= ST_RUN;
            deep_mode <= 1'b0;
            from_nmi <= 1'b0;
            restart_cnt <= '0;
        end else begin
            state <= next_state;
            deep_mode <= next_deep_mode;
            from_nmi <= next_from_nmi;
            restart_cnt <= next_restart_cnt;
        end
    end

    // clock gates and visible state straight from the state registers, handler deferral from the wake detector
    always_comb begin
        o_core_run = (state == ST_RUN); // R14
        o_sleeping = (state == ST_SLEEP_WFI) || (state == ST_SLEEP_WFE);
        o_cpu_clk_en = (state == ST_RUN) || (state == ST_LOCKUP); // R5
        o_sys_clk_en = !(o_sleeping && deep_mode); // R5
        o_pll_en = !(o_sleeping && deep_mode); // R5
        o_flash_en = !(o_sleeping && deep_mode); // R5
        o_locked_up = (state == ST_LOCKUP);
        o_defer_handler = w.defer_handler; // R8
    end

    // interrupt events
    assign sleep_entry = (state == ST_RUN) && ((next_state == ST_SLEEP_WFI)
        || (next_state == ST_SLEEP_WFE));
    assign wake_pulse = o_sleeping && (next_state != state);
    assign ev[EV_SLEEP] = sleep_entry;
    assign ev[EV_WAKE] = wake_pulse;
    assign ev[EV_LOCKUP] = lock_entry;

    // register writes, read-clear status with set winning over the clear
    always_comb begin
        next_sleep_after_handler = sleep_after_handler;
        next_deep_sleep_select = deep_sleep_select;
        next_event_on_pending = event_on_pending;
        next_irq_mask = irq_mask;
        if (i_wr && i_addr == OFS_SYS_CTRL) begin
            next_sleep_after_handler = i_wdata[SCR_SLEEP_AFTER_HANDLER];
            next_deep_sleep_select = i_wdata[SCR_DEEP_SLEEP_SELECT];
            next_event_on_pending = i_wdata[SCR_EVENT_ON_PENDING];
        end
        if (i_wr && i_addr == OFS_MASK) begin
            next_irq_mask = i_wdata[NUM_EV-1:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EV; gi++) begin : g_status
            always_comb begin
                next_status[gi] = status[gi];
                if (i_rd && i_addr == OFS_STATUS) begin
                    next_status[gi] = 1'b0;
                end
                if (ev[gi]) begin
                    next_status[gi] = 1'b1;
                end
            end
        end
    endgenerate

    // read data one cycle after the strobe, zero otherwise and for unmapped offsets
    always_comb begin
        next_rdata = '0;
        if (i_rd) begin
            unique case (i_addr)
                OFS_SYS_CTRL: begin
                    next_rdata[SCR_SLEEP_AFTER_HANDLER] = sleep_after_handler;
                    next_rdata[SCR_DEEP_SLEEP_SELECT] = deep_sleep_select;
                    next_rdata[SCR_EVENT_ON_PENDING] = event_on_pending;
                end
                OFS_STATUS: next_rdata[NUM_EV-1:0] = status;
                OFS_MASK: next_rdata[NUM_EV-1:0] = irq_mask;
                OFS_STATE: next_rdata[7:0] = {from_nmi, latch_q, deep_mode, state};
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sleep_after_handler <= SCR_RESET[0];
            deep_sleep_select <= SCR_RESET[1];
            event_on_pending <= SCR_RESET[2];
            irq_mask <= MASK_RESET;
            status <= '0;
            o_rdata <= '0;
            o_irq <= 1'b0;
        end else begin
            sleep_after_handler <= next_sleep_after_handler;
            deep_sleep_select <= next_deep_sleep_select;
            event_on_pending <= next_event_on_pending;
            irq_mask <= next_irq_mask;
            status <= next_status;
            o_rdata <= next_rdata;
            o_irq <= |(next_status & next_irq_mask);
        end
    end

    // assertion helper: cycles spent restarting clocks
    logic [CNT_W-1:0] restart_seen;
    always_ff @(posedge i_clk) begin
        if (i_rst || state != ST_RESTART) begin
            restart_seen <= '0;
        end else begin
            restart_seen <= restart_seen + CNT_W'(1);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_wfi_enter: assert property ( // R1
        state == ST_RUN && i_wfi_op && !lock_entry |=> state == ST_SLEEP_WFI && !o_core_run)
        else $error("wait-for-interrupt did not sleep");
    a_wfe_enter: assert property ( // R2
        state == ST_RUN && i_wfe_op && !latch_q && !i_wfi_op && !lock_entry
        |=> state == ST_SLEEP_WFE)
        else $error("wait-for-event with clear latch did not sleep");
    a_wfe_skip: assert property ( // R3
        state == ST_RUN && i_wfe_op && latch_q && !i_wfi_op && !lock_entry && !event_now
        |=> state == ST_RUN && !latch_q)
        else $error("wait-for-event with set latch slept or kept latch");
    a_exit_sleep: assert property ( // R4
        state == ST_RUN && i_handler_done && sleep_after_handler && !i_wfi_op
        && !i_wfe_op && !lock_entry |=> o_sleeping)
        else $error("sleep after handler not entered");
    a_deep_gates: assert property ( // R5
        o_sleeping |-> (o_sys_clk_en == !deep_mode) && (o_pll_en == o_sys_clk_en)
        && (o_flash_en == o_sys_clk_en) && !o_cpu_clk_en)
        else $error("clock gating does not match sleep depth");
    a_depth_select: assert property ( // R6
        sleep_entry |=> deep_mode == $past(deep_sleep_select))
        else $error("sleep depth not taken from select bit");
    a_wfi_hold: assert property ( // R7
        state == ST_SLEEP_WFI && !i_exc_entry_ok && !i_debug_wake
        && !(i_interrupt_mask_bit && !i_fault_mask_bit && i_irq_above_prio)
        |=> state == ST_SLEEP_WFI)
        else $error("wait-for-interrupt sleep ended without cause");
    a_masked_wake: assert property ( // R8
        state == ST_SLEEP_WFI && i_interrupt_mask_bit && !i_fault_mask_bit && i_irq_above_prio
        |-> o_defer_handler ##1 !o_sleeping)
        else $error("masked interrupt did not wake with deferral");
    a_event_wake: assert property ( // R9
        state == ST_SLEEP_WFE && (i_ext_event || i_remote_sev) |=> !o_sleeping)
        else $error("event did not wake wait-for-event sleep");
    a_pend_wake: assert property ( // R10
        state == ST_SLEEP_WFE && event_on_pending && i_new_pending |=> !o_sleeping)
        else $error("pending interrupt event did not wake");
    a_debug_wake: assert property ( // R12
        o_sleeping && i_debug_wake |=> !o_sleeping)
        else $error("debug wake ignored");
    a_lock_enter: assert property ( // R13
        state == ST_RUN && i_hard_fault && (i_in_nmi || i_in_hard_fault) |=> o_locked_up)
        else $error("lockup not entered");
    a_lock_hold: assert property ( // R14
        o_locked_up && !i_nmi && !i_debug_halt |=> o_locked_up && !o_core_run)
        else $error("lockup left without cause");
    a_nmi_lock: assert property ( // R15
        o_locked_up && from_nmi && !i_debug_halt |=> o_locked_up)
        else $error("nmi released nmi-caused lockup");
    a_restart_bound: assert property ( // R16
        state == ST_RESTART |-> restart_seen < CNT_W'(RESTART_LEN))
        else $error("clock restart took too long");

    c_deep_cycle: cover property (o_sleeping && deep_mode ##1 state == ST_RESTART);
    c_wfe_event: cover property (state == ST_SLEEP_WFE && i_ext_event ##1 o_core_run);
    c_lock_nmi: cover property (o_locked_up && !from_nmi && i_nmi ##1 o_core_run);
    c_irq_out: cover property (o_irq);
endmodule : core_sleep_lockup_control

// ===== src/event_latch.sv
// one-bit event latch set by events and cleared by a consuming wait-for-event
`timescale 1ns/100ps
module event_latch (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_set,
    input wire logic i_clear,
    output logic o_q
);
    logic next_q;

    // set wins over clear so a coinciding event is never lost
    always_comb begin
        next_q = o_q;
        if (i_clear) begin
            next_q = 1'b0;
        end
        if (i_set) begin
            next_q = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_q <= 1'b0;
        end else begin
            o_q <= next_q;
        end
    end
endmodule : event_latch

// ===== src/sleep_ctl_pkg.sv
// constants, state encoding and register map of the core sleep and lockup controller
//
// Function
// R1 - A wait-for-interrupt instruction stops instruction issue and enters sleep at once.
// R2 - A wait-for-event instruction with the event latch at 0 stops issue and enters sleep.
// R3 - A wait-for-event instruction with the event latch at 1 clears it and keeps running.
// R4 - With sleep_after_handler at 1, a completed handler returns to thread and sleeps.
// R5 - Normal sleep gates the core clock; deep sleep also stops system clock, PLL and flash.
// R6 - The deep_sleep_select bit of system_control_reg picks normal or deep sleep at entry.
// R7 - Sleep from wait-for-interrupt or sleep-after-handler ends only on an entry-capable exception.
// R8 - With interrupt mask 1 and fault mask 0 a higher enabled interrupt wakes, handler deferred.
// R9 - Wait-for-event sleep ends on an entry-capable exception, an external or a remote event.
// R10 - With event_on_pending at 1 each newly pending interrupt raises a waking event.
// R11 - Peripherals pulse the event input to wake wait-for-event sleep or to set the latch.
// R12 - A debug operation may wake the core spuriously and the core then resumes execution.
// R13 - A hard fault inside the non-maskable or hard fault handler enters lockup.
// R14 - Lockup issues no instructions and ends only on reset, a non-maskable interrupt or halt.
// R15 - Lockup entered from the non-maskable handler is not released by a further one.
// R16 - Every wake resumes execution and ungates stopped clocks within a bounded cycle count.
package sleep_ctl_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [3:0] OFS_SYS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_MASK = 4'h8;
    localparam logic [3:0] OFS_STATE = 4'hC;
    // system_control_reg fields
    localparam int SCR_SLEEP_AFTER_HANDLER = 1;
    localparam int SCR_DEEP_SLEEP_SELECT = 2;
    localparam int SCR_EVENT_ON_PENDING = 4;
    localparam logic [2:0] SCR_RESET = 3'h0;
    // status and mask fields
    localparam int NUM_EV = 3;
    localparam int EV_SLEEP = 0;
    localparam int EV_WAKE = 1;
    localparam int EV_LOCKUP = 2;
    localparam logic [2:0] MASK_RESET = 3'h0;
    // timing: clock restart after deep sleep
    localparam int CLK_PERIOD_NS = 100;
    localparam int RESTART_NS = 1000;
    localparam int RESTART_CYCLES = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_SLEEP_WFI = 5'h02,
        ST_SLEEP_WFE = 5'h04,
        ST_RESTART = 5'h08,
        ST_LOCKUP = 5'h10
    } ctl_state_t;
endpackage : sleep_ctl_pkg

// ===== src/wake_detect.sv
// combinational wake decision for each sleep cause
`timescale 1ns/100ps
module wake_detect (
    wake_if.detect w
);
    logic masked_wake;

    always_comb begin
        // interrupt wakes the core although the mask holds off its handler
        masked_wake = w.int_mask && !w.fault_mask && w.irq_above_prio; // R8
        // an exception able to enter, a masked higher interrupt or debug ends this sleep; debug is the spurious exception
        w.wake_wfi = w.exc_entry_ok || masked_wake || w.debug_wake; // R7 R12
        // events, remote send and pending-event all arrive through event_now or the latch
        w.wake_wfe = w.wake_wfi || w.event_now || w.latch_q; // R9
        w.defer_handler = w.int_mask && !w.fault_mask; // R8
    end
endmodule : wake_detect

// ===== src/wake_if.sv
// wake condition signals passed between the controller and the wake detector
`timescale 1ns/100ps
interface wake_if;
    logic exc_entry_ok;
    logic irq_above_prio;
    logic int_mask;
    logic fault_mask;
    logic event_now;
    logic latch_q;
    logic debug_wake;
    logic wake_wfi;
    logic wake_wfe;
    logic defer_handler;
    modport detect (
        input exc_entry_ok, irq_above_prio, int_mask, fault_mask, event_now, latch_q,
        input debug_wake,
        output wake_wfi, wake_wfe, defer_handler
    );
    modport ctrl (
        output exc_entry_ok, irq_above_prio, int_mask, fault_mask, event_now, latch_q,
        output debug_wake,
        input wake_wfi, wake_wfe, defer_handler
    );
endinterface : wake_if

// ===== tb/core_sleep_lockup_control_tb.sv
// self-checking bench of the sleep, wake and lockup controller
`timescale 1ns/100ps
module core_sleep_lockup_control_tb import sleep_ctl_pkg::*; ;
    localparam int RL = 2;
    localparam int wait_int = 0, wait_ev = 1, hdone = 2, hfault = 3;
    localparam int nmi = 4, dbg_wake = 5, dbg_halt = 6;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0, i_rd = 1'b0;
    logic [6:0] pl = 7'h0;
    logic i_exc_entry_ok = 1'b0, i_irq_above_prio = 1'b0, i_interrupt_mask_bit = 1'b0;
    logic i_fault_mask_bit = 1'b0, i_in_nmi = 1'b0, i_in_hard_fault = 1'b0;
    logic go = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [3:0] dly = 4'h0;
    logic i_new_pending, i_ext_event, i_remote_sev;
    logic [31:0] o_rdata;
    logic o_core_run, o_cpu_clk_en, o_sys_clk_en, o_pll_en, o_flash_en, o_sleeping;
    logic o_locked_up, o_defer_handler, o_irq;
    int num_errors = 0, tests_run = 0;

    core_sleep_lockup_control #(.RESTART_LEN(RL)) dut (
        .i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_wfi_op(pl[0]), .i_wfe_op(pl[1]), .i_handler_done(pl[2]), .i_hard_fault(pl[3]),
        .i_nmi(pl[4]), .i_debug_wake(pl[5]), .i_debug_halt(pl[6]),
        .i_exc_entry_ok, .i_irq_above_prio, .i_interrupt_mask_bit, .i_fault_mask_bit,
        .i_new_pending, .i_ext_event, .i_remote_sev, .i_in_nmi, .i_in_hard_fault,
        .o_core_run, .o_cpu_clk_en, .o_sys_clk_en, .o_pll_en, .o_flash_en, .o_sleeping,
        .o_locked_up, .o_defer_handler, .o_irq
    );
    event_source_model partner (.i_clk, .i_go(go), .i_kind(kind), .i_delay(dly),
        .o_ext_event(i_ext_event), .o_remote_sev(i_remote_sev), .o_new_pending(i_new_pending));

    // 100 ns clock
    always #50 i_clk = ~i_clk;

    function automatic logic wake_exp(input logic [1:0] k, input logic pend_ev);
        return (k != 2'h3) || pend_ev;
    endfunction : wake_exp
    function automatic logic defer_exp(input logic m, input logic f);
        return m && !f;
    endfunction : defer_exp

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        check(o_rdata, e, "register read");
    endtask : rd_chk
    task automatic pulse(input int b);
        @(posedge i_clk);
        pl[b] <= 1'b1;
        @(posedge i_clk);
        pl[b] <= 1'b0;
        #1;
    endtask : pulse
    task automatic fire(input logic [1:0] k, input logic [3:0] d);
        @(posedge i_clk);
        go <= 1'b1;
        kind <= k;
        dly <= d;
        @(posedge i_clk);
        go <= 1'b0;
        #1;
    endtask : fire
    // bounded wait for the core to run again; running out of it ends the run
    task automatic wait_run(output int n);
        n = 0;
        while (o_core_run !== 1'b1 && n < 40) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n == 40) begin
            num_errors++;
            $display("MISMATCH t=%0t wake wait ran out", $time);
            summarize();
        end
    endtask : wait_run
    task automatic wake_chk(input int e);
        int n;
        i_exc_entry_ok <= 1'b1;
        wait_run(n);
        i_exc_entry_ok <= 1'b0;
        check(n, e, "wake cycles");
    endtask : wake_chk

    initial begin
        int n;
        logic [1:0] kd;
        logic [3:0] d;
        void'($urandom(32'h67BE));
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        rd_chk(OFS_SYS_CTRL, 32'h0);
        rd_chk(OFS_MASK, 32'h0);
        rd_chk(OFS_STATE, 32'h1);
        rd_chk(4'h2, 32'h0);
        $display("test reset_values done");
        pulse(wait_int);
        check({o_sleeping, o_core_run, o_cpu_clk_en, o_sys_clk_en}, 4'h9, "wfi");
        fire(2'h1, 4'h0);
        repeat (4) @(posedge i_clk);
        rd_chk(OFS_STATE, 32'h42);
        wake_chk(1);
        $display("test wfi_sleep done");
        rd_chk(OFS_STATUS, 32'h3);
        wr(OFS_MASK, 32'h1);
        wr(OFS_SYS_CTRL, 32'h4);
        pulse(wait_int);
        check({o_sys_clk_en, o_pll_en, o_flash_en, o_cpu_clk_en}, 4'h0, "deep");
        repeat (2) @(posedge i_clk);
        check(o_irq, 1'b1, "irq raised");
        wake_chk(RL + 1);
        rd_chk(OFS_STATUS, 32'h3);
        repeat (2) @(posedge i_clk);
        check(o_irq, 1'b0, "irq cleared");
        wr(OFS_MASK, 32'h0);
        wr(OFS_SYS_CTRL, 32'h0);
        $display("test deep_sleep done");
        pulse(wait_ev);
        check(o_sleeping, 1'b0, "wfe with latch set");
        rd_chk(OFS_STATE, 32'h1);
        // every event source, plus a pending interrupt with event_on_pending off
        for (int k = 0; k < 4; k++) begin
            kd = (k == 3) ? 2'h3 : 2'(k + 1);
            wr(OFS_SYS_CTRL, (k == 3) ? 32'h0 : 32'h10);
            pulse(wait_ev);
            check(o_sleeping, 1'b1, "wfe sleep");
            d = 4'($urandom_range(0, 7));
            fire(kd, d);
            if (wake_exp(kd, k != 3)) begin
                wait_run(n);
                check(n, d + 1, "event wake");
            end else begin
                repeat (d + 4) @(posedge i_clk);
                check(o_sleeping, 1'b1, "pending ignored");
                wake_chk(1);
            end
        end
        wr(OFS_SYS_CTRL, 32'h0);
        $display("test wfe_sleep done");
        pulse(hdone);
        check(o_sleeping, 1'b0, "handler no sleep");
        wr(OFS_SYS_CTRL, 32'h2);
        pulse(hdone);
        check(o_sleeping, 1'b1, "sleep after handler");
        pulse(dbg_wake);
        check(o_core_run, 1'b1, "debug wake");
        wr(OFS_SYS_CTRL, 32'h0);
        $display("test handler_sleep done");
        for (int m = 0; m < 4; m++) begin
            i_interrupt_mask_bit <= m[1];
            i_fault_mask_bit <= m[0];
            #1;
            check(o_defer_handler, defer_exp(m[1], m[0]), "defer");
        end
        i_interrupt_mask_bit <= 1'b1;
        i_fault_mask_bit <= 1'b0;
        pulse(wait_int);
        i_irq_above_prio <= 1'b1;
        wait_run(n);
        check(n, 1, "masked irq wake");
        i_irq_above_prio <= 1'b0;
        i_interrupt_mask_bit <= 1'b0;
        $display("test masked_wake done");
        i_in_hard_fault <= 1'b1;
        pulse(hfault);
        check({o_locked_up, o_core_run, o_cpu_clk_en}, 3'h5, "lockup");
        pulse(wait_int);
        check({o_sleeping, o_locked_up}, 2'h1, "no issue in lockup");
        pulse(nmi);
        check(o_locked_up, 1'b0, "nmi release");
        i_in_hard_fault <= 1'b0;
        i_in_nmi <= 1'b1;
        pulse(hfault);
        pulse(nmi);
        check(o_locked_up, 1'b1, "nmi no release");
        pulse(dbg_halt);
        check(o_locked_up, 1'b0, "halt release");
        i_in_nmi <= 1'b0;
        rd_chk(OFS_STATUS, 32'h7);
        $display("test lockup done");
        summarize();
    end
endmodule : core_sleep_lockup_control_tb

// ===== tb/event_source_model.sv
// peripheral and exception-side model that raises wake events after a chosen delay
`timescale 1ns/100ps
module event_source_model (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [1:0] i_kind,
    input wire logic [3:0] i_delay,
    output logic o_ext_event,
    output logic o_remote_sev,
    output logic o_new_pending
);
    // one-cycle pulse after a delay, so prompt and slow sources both show up
    always @(posedge i_clk) begin
        if (i_go) begin
            repeat (i_delay) @(posedge i_clk);
            o_ext_event <= (i_kind == 2'h1);
            o_remote_sev <= (i_kind == 2'h2);
            o_new_pending <= (i_kind == 2'h3);
            @(posedge i_clk);
            o_ext_event <= 1'b0;
            o_remote_sev <= 1'b0;
            o_new_pending <= 1'b0;
        end else begin
            o_ext_event <= 1'b0;
            o_remote_sev <= 1'b0;
            o_new_pending <= 1'b0;
        end
    end
endmodule : event_source_model
